// File: design/bbcm_consts.vh
// Offsets, field positions, reset values and timing counts of the matcher
`ifndef BBCM_CONSTS_VH
`define BBCM_CONSTS_VH
`define BBCM_A_CTRL 12'h000
`define BBCM_A_U1_ADDR 12'h004
`define BBCM_A_U1_AMSK 12'h008
`define BBCM_A_U1_DATA 12'h00C
`define BBCM_A_U1_DMSK 12'h010
`define BBCM_A_U1_CFG 12'h014
`define BBCM_A_U2_ADDR 12'h018
`define BBCM_A_U2_AMSK 12'h01C
`define BBCM_A_U2_CFG 12'h020
`define BBCM_A_U3_ADDR 12'h024
`define BBCM_A_U3_CFG 12'h028
`define BBCM_A_U4_ADDR 12'h02C
`define BBCM_A_U4_CFG 12'h030
`define BBCM_A_U5_CFG 12'h034
`define BBCM_A_SEQ_P0 12'h038
`define BBCM_A_SEQ_P1 12'h03C
`define BBCM_A_SEQ_P2 12'h040
`define BBCM_A_SEQ_P3 12'h044
`define BBCM_A_SEQ_RST 12'h048
`define BBCM_A_SEQ_CFG 12'h04C
`define BBCM_A_CANCEL 12'h050
`define BBCM_A_STATUS 12'h054
`define BBCM_A_DLY_CNT 12'h058
// Config fields: en, rd, wr, type[1:0], size[1:0], pc, delay[11:0]
`define BBCM_F_EN 0
`define BBCM_F_RD 1
`define BBCM_F_WR 2
`define BBCM_F_TYP_LO 3
`define BBCM_F_TYP_HI 4
`define BBCM_F_SZ_LO 5
`define BBCM_F_SZ_HI 6
`define BBCM_F_PC 7
`define BBCM_F_DLY_LO 16
`define BBCM_F_DLY_HI 27
// Cycle type and size codes
`define BBCM_TYP_ALL 2'h0
`define BBCM_TYP_EXEC 2'h1
`define BBCM_TYP_DMA 2'h2
`define BBCM_SZ_BYTE 2'h0
`define BBCM_SZ_HALF 2'h1
`define BBCM_SZ_LONG 2'h2
// Sequence config: count of pass points [2:0], reset point enable [3]
`define BBCM_F_SEQ_RST_EN 3
`define BBCM_RST_ZERO 32'h00000000
// Instructions that must retire between match and halt
`define BBCM_HALT_INSNS 2'h2
`endif

// File: design/bbcm_matcher.v
// Bus break condition matcher with APB register access
// Behaviour
// - Units three and four match on address
// - Read or write qualifier restricts matches
// - Unit five matches on probe trigger
// - Unit one needs address and data match
// - Long-word compare: aligned four, one cycle
// - Half-word compare: aligned two, one cycle
// - Byte compare: any address, one cycle
// - Masked bits always match in units one, two
// - Masks are per bit, any nibble works
// - Halt after at least two more instructions
// - Unit one keeps readable delay count
// - Cancel all or one named unit
// - Unit two off during stop-address run, stepping
// - All address bits compared, no aliasing
// - Software breakpoint execution invalidates unit two
// - Delay slot never halts before PC break
// - PC-relative access counts as execution cycle
// - Units one, two use on-chip break controller
// - Ordered pass-point breaks supported
// - Pass and reset points rounded to even
// - Cycle type: all, execution or DMA
// - Delay count postpones firing by bus cycles
// - Sequence ends run; misorder restarts
// - Reset point restarts sequence checking
`include "bbcm_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module bbcm_matcher (
	// Clock and reset
	input wire core_clk_i,
	input wire rst_i,
	// APB slave
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	output wire pready_o,
	output wire pslverr_o,
	output reg [31:0] prdata_o,
	// Target bus observation
	input wire bus_valid_i,
	input wire [31:0] bus_addr_i,
	input wire [31:0] bus_data_i,
	input wire bus_write_i,
	input wire [1:0] bus_size_i,
	input wire bus_fetch_i,
	input wire bus_exec_i,
	input wire bus_dma_i,
	input wire bus_pc_rel_i,
	// Execution status
	input wire insn_retire_i,
	input wire insn_in_slot_i,
	input wire sw_break_exec_i,
	input wire run_stop_addr_i,
	input wire stepping_i,
	input wire external_probe_trigger_i,
	// Emulation control
	output reg stop_req_o,
	output reg [4:0] hit_units_o
);
	localparam ST_IDLE = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_HALT = 3'b100;
	reg [31:0] u1_addr_reg, u1_amsk_reg, u1_data_reg, u1_dmsk_reg, u1_cfg_reg;
	reg [31:0] u2_addr_reg, u2_amsk_reg, u2_cfg_reg;
	reg [31:0] u3_addr_reg, u3_cfg_reg, u4_addr_reg, u4_cfg_reg, u5_cfg_reg;
	reg [31:0] p0_reg, p1_reg, p2_reg, p3_reg, prst_reg, seq_cfg_reg;
	reg [2:0] seq_idx_reg;
	reg [11:0] d1_cnt_reg, d2_cnt_reg;
	reg d1_arm_reg, d2_arm_reg;
	reg [15:0] dly_since_reg;
	reg [2:0] state_reg;
	reg [1:0] insn_cnt_reg;
	reg seq_done_reg;
	wire wr_en = psel_i & penable_i & pwrite_i;
	assign pready_o = 1'b1;
	reg addr_ok;
	always @* begin
		case (paddr_i)
		`BBCM_A_CTRL, `BBCM_A_U1_ADDR, `BBCM_A_U1_AMSK, `BBCM_A_U1_DATA,
		`BBCM_A_U1_DMSK, `BBCM_A_U1_CFG, `BBCM_A_U2_ADDR, `BBCM_A_U2_AMSK,
		`BBCM_A_U2_CFG, `BBCM_A_U3_ADDR, `BBCM_A_U3_CFG, `BBCM_A_U4_ADDR,
		`BBCM_A_U4_CFG, `BBCM_A_U5_CFG, `BBCM_A_SEQ_P0, `BBCM_A_SEQ_P1,
		`BBCM_A_SEQ_P2, `BBCM_A_SEQ_P3, `BBCM_A_SEQ_RST, `BBCM_A_SEQ_CFG,
		`BBCM_A_CANCEL, `BBCM_A_STATUS, `BBCM_A_DLY_CNT: addr_ok = 1'b1;
		default: addr_ok = 1'b0;
		endcase
	end
	assign pslverr_o = psel_i & penable_i & ~addr_ok;
	// Qualifier for one unit's config
	function qual_ok;
		input [31:0] cfg;
		reg tok;
		begin
			case (cfg[`BBCM_F_TYP_HI:`BBCM_F_TYP_LO])
			`BBCM_TYP_EXEC: tok = bus_exec_i | bus_pc_rel_i;
			`BBCM_TYP_DMA: tok = bus_dma_i;
			default: tok = 1'b1;
			endcase
			qual_ok = tok & (~cfg[`BBCM_F_RD] | ~bus_write_i) &
				(~cfg[`BBCM_F_WR] | bus_write_i);
		end
	endfunction
	// Masked compare on every address bit
	wire a1_hit = ((bus_addr_i ^ u1_addr_reg) & ~u1_amsk_reg) == 32'h0;
	wire a2_hit = ((bus_addr_i ^ u2_addr_reg) & ~u2_amsk_reg) == 32'h0;
	// Data compare lane by size, aligned addresses for long and half, any for byte
	reg d1_hit;
	always @* begin
		d1_hit = 1'b0;
		if (bus_size_i == u1_cfg_reg[`BBCM_F_SZ_HI:`BBCM_F_SZ_LO]) begin
			case (u1_cfg_reg[`BBCM_F_SZ_HI:`BBCM_F_SZ_LO])
			`BBCM_SZ_LONG: d1_hit = (u1_addr_reg[1:0] == 2'h0) &
				(((bus_data_i ^ u1_data_reg) & ~u1_dmsk_reg) == 32'h0);
			`BBCM_SZ_HALF: d1_hit = ~u1_addr_reg[0] &
				(((bus_data_i[15:0] ^ u1_data_reg[15:0]) &
				~u1_dmsk_reg[15:0]) == 16'h0);
			default: d1_hit = (((bus_data_i[7:0] ^ u1_data_reg[7:0]) &
				~u1_dmsk_reg[7:0]) == 8'h0);
			endcase
		end
	end
	// Units one and two sit on the on-chip break controller
	wire u1_raw = u1_cfg_reg[`BBCM_F_EN] & bus_valid_i & ~bus_fetch_i &
		a1_hit & d1_hit & qual_ok(u1_cfg_reg);
	wire u2_act = u2_cfg_reg[`BBCM_F_EN] & ~run_stop_addr_i & ~stepping_i;
	wire u2_raw = u2_act & bus_valid_i & a2_hit &
		(u2_cfg_reg[`BBCM_F_PC] ? bus_fetch_i : qual_ok(u2_cfg_reg));
	wire u3_raw = u3_cfg_reg[`BBCM_F_EN] & bus_valid_i &
		(bus_addr_i == u3_addr_reg) & qual_ok(u3_cfg_reg);
	wire u4_raw = u4_cfg_reg[`BBCM_F_EN] & bus_valid_i &
		(bus_addr_i == u4_addr_reg) & qual_ok(u4_cfg_reg);
	wire u5_hit = u5_cfg_reg[`BBCM_F_EN] & external_probe_trigger_i;
	wire [11:0] d1_set = u1_cfg_reg[`BBCM_F_DLY_HI:`BBCM_F_DLY_LO];
	wire [11:0] d2_set = u2_cfg_reg[`BBCM_F_DLY_HI:`BBCM_F_DLY_LO];
	wire u1_hit = (d1_set == 12'h000) ? u1_raw :
		(d1_arm_reg & bus_valid_i & (d1_cnt_reg == 12'h001));
	wire u2_hit = (d2_set == 12'h000) ? u2_raw :
		(d2_arm_reg & bus_valid_i & (d2_cnt_reg == 12'h001) & u2_act);
	// Pass sequence, addresses rounded to even
	wire [31:0] pc_even = {bus_addr_i[31:1], 1'b0};
	reg [31:0] cur_pt;
	always @* begin
		case (seq_idx_reg)
		3'h0: cur_pt = p0_reg;
		3'h1: cur_pt = p1_reg;
		3'h2: cur_pt = p2_reg;
		default: cur_pt = p3_reg;
		endcase
	end
	wire [2:0] seq_n = seq_cfg_reg[2:0];
	wire seq_on = (seq_n != 3'h0) & bus_valid_i & bus_fetch_i & ~stepping_i;
	wire hit_p = (pc_even == p0_reg) | ((pc_even == p1_reg) & (seq_n > 3'h1)) |
		((pc_even == p2_reg) & (seq_n > 3'h2)) |
		((pc_even == p3_reg) & (seq_n > 3'h3));
	wire hit_rst = seq_cfg_reg[`BBCM_F_SEQ_RST_EN] & (pc_even == prst_reg);
	wire hit_cur = pc_even == cur_pt;
	wire seq_fire = seq_on & ~hit_rst & hit_cur & (seq_idx_reg + 3'h1 == seq_n);
	wire any_hit = u1_hit | u2_hit | u3_raw | u4_raw | u5_hit | seq_fire;
	wire [4:0] cancel = (wr_en & (paddr_i == `BBCM_A_CANCEL)) ?
		((pwdata_i[4:0] == 5'h00) ? 5'h1F : pwdata_i[4:0]) : 5'h00;
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			u1_addr_reg <= `BBCM_RST_ZERO;
			u1_amsk_reg <= `BBCM_RST_ZERO;
			u1_data_reg <= `BBCM_RST_ZERO;
			u1_dmsk_reg <= `BBCM_RST_ZERO;
			u1_cfg_reg <= `BBCM_RST_ZERO;
			u2_addr_reg <= `BBCM_RST_ZERO;
			u2_amsk_reg <= `BBCM_RST_ZERO;
			u2_cfg_reg <= `BBCM_RST_ZERO;
			u3_addr_reg <= `BBCM_RST_ZERO;
			u3_cfg_reg <= `BBCM_RST_ZERO;
			u4_addr_reg <= `BBCM_RST_ZERO;
			u4_cfg_reg <= `BBCM_RST_ZERO;
			u5_cfg_reg <= `BBCM_RST_ZERO;
			p0_reg <= `BBCM_RST_ZERO;
			p1_reg <= `BBCM_RST_ZERO;
			p2_reg <= `BBCM_RST_ZERO;
			p3_reg <= `BBCM_RST_ZERO;
			prst_reg <= `BBCM_RST_ZERO;
			seq_cfg_reg <= `BBCM_RST_ZERO;
		end else begin
			if (wr_en) begin
				case (paddr_i)
				`BBCM_A_U1_ADDR: u1_addr_reg <= pwdata_i;
				`BBCM_A_U1_AMSK: u1_amsk_reg <= pwdata_i;
				`BBCM_A_U1_DATA: u1_data_reg <= pwdata_i;
				`BBCM_A_U1_DMSK: u1_dmsk_reg <= pwdata_i;
				`BBCM_A_U1_CFG: u1_cfg_reg <= pwdata_i;
				`BBCM_A_U2_ADDR: u2_addr_reg <= pwdata_i;
				`BBCM_A_U2_AMSK: u2_amsk_reg <= pwdata_i;
				`BBCM_A_U2_CFG: u2_cfg_reg <= pwdata_i;
				`BBCM_A_U3_ADDR: u3_addr_reg <= pwdata_i;
				`BBCM_A_U3_CFG: u3_cfg_reg <= pwdata_i;
				`BBCM_A_U4_ADDR: u4_addr_reg <= pwdata_i;
				`BBCM_A_U4_CFG: u4_cfg_reg <= pwdata_i;
				`BBCM_A_U5_CFG: u5_cfg_reg <= pwdata_i;
				`BBCM_A_SEQ_P0: p0_reg <= {pwdata_i[31:1], 1'b0};
				`BBCM_A_SEQ_P1: p1_reg <= {pwdata_i[31:1], 1'b0};
				`BBCM_A_SEQ_P2: p2_reg <= {pwdata_i[31:1], 1'b0};
				`BBCM_A_SEQ_P3: p3_reg <= {pwdata_i[31:1], 1'b0};
				`BBCM_A_SEQ_RST: prst_reg <= {pwdata_i[31:1], 1'b0};
				`BBCM_A_SEQ_CFG: seq_cfg_reg <= pwdata_i;
				default: ;
				endcase
			end
			if (cancel[0])
				u1_cfg_reg <= `BBCM_RST_ZERO;
			if (cancel[1] | (sw_break_exec_i & bus_valid_i))
				u2_cfg_reg <= `BBCM_RST_ZERO;
			if (cancel[2])
				u3_cfg_reg <= `BBCM_RST_ZERO;
			if (cancel[3])
				u4_cfg_reg <= `BBCM_RST_ZERO;
			if (cancel[4])
				u5_cfg_reg <= `BBCM_RST_ZERO;
		end
	end
	// Delay counters count bus cycles after the raw condition
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			d1_arm_reg <= 1'b0;
			d1_cnt_reg <= 12'h000;
			d2_arm_reg <= 1'b0;
			d2_cnt_reg <= 12'h000;
			dly_since_reg <= 16'h0000;
		end else begin
			if (cancel[0] | (d1_set == 12'h000)) begin
				d1_arm_reg <= 1'b0;
			end else if (~d1_arm_reg & u1_raw) begin
				d1_arm_reg <= 1'b1;
				d1_cnt_reg <= d1_set;
			end else if (d1_arm_reg & bus_valid_i) begin
				d1_cnt_reg <= d1_cnt_reg - 12'h001;
				if (d1_cnt_reg == 12'h001)
					d1_arm_reg <= 1'b0;
			end
			if (cancel[1] | (d2_set == 12'h000) | ~u2_act) begin
				d2_arm_reg <= 1'b0;
			end else if (~d2_arm_reg & u2_raw) begin
				d2_arm_reg <= 1'b1;
				d2_cnt_reg <= d2_set;
			end else if (d2_arm_reg & bus_valid_i) begin
				d2_cnt_reg <= d2_cnt_reg - 12'h001;
				if (d2_cnt_reg == 12'h001)
					d2_arm_reg <= 1'b0;
			end
			if (cancel[0] | u1_raw)
				dly_since_reg <= 16'h0000;
			else if (bus_valid_i & (dly_since_reg != 16'hFFFF))
				dly_since_reg <= dly_since_reg + 16'h0001;
		end
	end
	// Sequence tracker
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			seq_idx_reg <= 3'h0;
			seq_done_reg <= 1'b0;
		end else if (wr_en & (paddr_i == `BBCM_A_SEQ_CFG)) begin
			seq_idx_reg <= 3'h0;
			seq_done_reg <= 1'b0;
		end else if (seq_on) begin
			if (hit_rst)
				seq_idx_reg <= 3'h0;
			else if (seq_fire) begin
				seq_idx_reg <= 3'h0;
				seq_done_reg <= 1'b1;
			end else if (hit_cur)
				seq_idx_reg <= seq_idx_reg + 3'h1;
			else if (hit_p)
				seq_idx_reg <= (pc_even == p0_reg) ? 3'h1 : 3'h0;
		end
	end
	// Halt after two retired instructions, not from a delay slot
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			insn_cnt_reg <= 2'h0;
			stop_req_o <= 1'b0;
			hit_units_o <= 5'h00;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				if (any_hit) begin
					state_reg <= ST_WAIT;
					insn_cnt_reg <= 2'h0;
					hit_units_o <= {u5_hit, u4_raw, u3_raw, u2_hit, u1_hit};
				end
			end
			ST_WAIT: begin
				if (insn_retire_i & (insn_cnt_reg != `BBCM_HALT_INSNS))
					insn_cnt_reg <= insn_cnt_reg + 2'h1;
				if ((insn_cnt_reg == `BBCM_HALT_INSNS) & ~insn_in_slot_i) begin
					state_reg <= ST_HALT;
					stop_req_o <= 1'b1;
				end
			end
			ST_HALT: begin
				if (wr_en & (paddr_i == `BBCM_A_CTRL) & pwdata_i[0]) begin
					state_reg <= ST_IDLE;
					stop_req_o <= 1'b0;
					hit_units_o <= 5'h00;
				end
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end
	// Read data
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			prdata_o <= 32'h00000000;
		end else if (psel_i & ~penable_i & ~pwrite_i) begin
			case (paddr_i)
			`BBCM_A_CTRL: prdata_o <= 32'h00000000;
			`BBCM_A_U1_ADDR: prdata_o <= u1_addr_reg;
			`BBCM_A_U1_AMSK: prdata_o <= u1_amsk_reg;
			`BBCM_A_U1_DATA: prdata_o <= u1_data_reg;
			`BBCM_A_U1_DMSK: prdata_o <= u1_dmsk_reg;
			`BBCM_A_U1_CFG: prdata_o <= u1_cfg_reg;
			`BBCM_A_U2_ADDR: prdata_o <= u2_addr_reg;
			`BBCM_A_U2_AMSK: prdata_o <= u2_amsk_reg;
			`BBCM_A_U2_CFG: prdata_o <= u2_cfg_reg;
			`BBCM_A_U3_ADDR: prdata_o <= u3_addr_reg;
			`BBCM_A_U3_CFG: prdata_o <= u3_cfg_reg;
			`BBCM_A_U4_ADDR: prdata_o <= u4_addr_reg;
			`BBCM_A_U4_CFG: prdata_o <= u4_cfg_reg;
			`BBCM_A_U5_CFG: prdata_o <= u5_cfg_reg;
			`BBCM_A_SEQ_P0: prdata_o <= p0_reg;
			`BBCM_A_SEQ_P1: prdata_o <= p1_reg;
			`BBCM_A_SEQ_P2: prdata_o <= p2_reg;
			`BBCM_A_SEQ_P3: prdata_o <= p3_reg;
			`BBCM_A_SEQ_RST: prdata_o <= prst_reg;
			`BBCM_A_SEQ_CFG: prdata_o <= seq_cfg_reg;
			`BBCM_A_STATUS: prdata_o <= {20'h00000, seq_done_reg, seq_idx_reg,
				hit_units_o, state_reg};
			`BBCM_A_DLY_CNT: prdata_o <= {16'h0000, dly_since_reg};
			default: prdata_o <= 32'h00000000;
			endcase
		end
	end
endmodule // bbcm_matcher
`default_nettype wire

// File: testbench/bbcm_matcher_sva.sv
// Port-level checker for the break condition matcher
`timescale 1ns/100ps
`default_nettype none
module bbcm_chk (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// APB
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	// Target and control
	input wire logic bus_valid_i,
	input wire logic insn_retire_i,
	input wire logic external_probe_trigger_i,
	input wire logic stop_req_o,
	input wire logic [4:0] hit_units_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	logic [1:0] rcnt;
	wire clr = penable_i & pwrite_i & (paddr_i == 12'h000) & pwdata_i[0];
	// Retired instructions since the hit was latched
	always_ff @(posedge core_clk_i or posedge rst_i)
		if (rst_i || stop_req_o || hit_units_o == 5'h00)
			rcnt <= 2'h0;
		else if (insn_retire_i && rcnt != 2'h3)
			rcnt <= rcnt + 2'h1;
	chk_stop_hold: assert property (stop_req_o && !clr |=> stop_req_o)
		else $error("stop request dropped");
	chk_stop_clear: assert property (stop_req_o && clr |=> !stop_req_o)
		else $error("stop request not cleared");
	chk_two_insns: assert property ($rose(stop_req_o) |-> rcnt >= 2'h2)
		else $error("stop before two instructions");
	chk_no_early: assert property ($rose(|hit_units_o) |-> !stop_req_o [*2])
		else $error("stop too soon after hit");
	chk_hits_held: assert property (stop_req_o && !clr |=> $stable(hit_units_o))
		else $error("hit units changed while stopped");
	chk_probe_hit: assert property ($rose(hit_units_o[4]) |->
		$past(external_probe_trigger_i)) else $error("unit five without probe");
	chk_bus_hit: assert property ($rose(|hit_units_o[3:0]) |-> $past(bus_valid_i))
		else $error("bus unit hit without bus cycle");
	chk_reset_clear: assert property ($fell(rst_i) |-> !stop_req_o && !hit_units_o)
		else $error("state not clear after reset");
	cover property ($rose(stop_req_o));
	cover property (stop_req_o && clr);
	cover property ($rose(hit_units_o[4]));
endmodule // bbcm_chk
bind bbcm_matcher bbcm_chk i_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .bus_valid_i(bus_valid_i), .insn_retire_i(insn_retire_i),
	.external_probe_trigger_i(external_probe_trigger_i),
	.stop_req_o(stop_req_o), .hit_units_o(hit_units_o));
`default_nettype wire

// File: testbench/bbcm_core_model.sv
// Target core model: bus cycles and retired instructions
`timescale 1ns/100ps
`default_nettype none
module bbcm_core_model (
	// Clock
	input wire logic clk_i,
	// Bus cycle
	output var logic valid_o,
	output var logic [31:0] addr_o,
	output var logic [31:0] data_o,
	output var logic wr_o,
	output var logic [1:0] size_o,
	output var logic fetch_o,
	output var logic exec_o,
	output var logic dma_o,
	// Instruction stream
	output var logic retire_o
);
	initial begin
		{valid_o, addr_o, data_o, wr_o, size_o, fetch_o, exec_o, dma_o, retire_o} = '0;
	end
	// One bus cycle, kind is size, write, type
	task cyc(input logic [31:0] a, input logic [31:0] d, input logic [4:0] k);
		valid_o <= 1'b1;
		addr_o <= a;
		data_o <= d;
		{size_o, wr_o} <= k[4:2];
		{fetch_o, exec_o, dma_o} <= 3'h4 >> k[1:0];
		@(posedge clk_i);
		{valid_o, wr_o} <= {1'b0, ~k[2]};
		addr_o <= ~a;
		data_o <= ~d;
		@(posedge clk_i);
	endtask
	// One retired instruction, then one to four idle cycles
	task retire(input logic [1:0] g);
		retire_o <= 1'b1;
		@(posedge clk_i);
		retire_o <= 1'b0;
		repeat (int'(g) + 1) @(posedge clk_i);
	endtask
endmodule // bbcm_core_model
`default_nettype wire

// File: testbench/bus_break_condition_matcher_tb.sv
// Self-checking bench for the break condition matcher
`include "bbcm_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module bus_break_condition_matcher_tb;
	logic ck, rs, psel, pen, pwr, prdy, perr, pe, probe, step, swb, stop;
	logic pcr, slot, rsa;
	logic [4:0] hit;
	logic [11:0] pa;
	logic [31:0] pwd, prd, r, a, d, x = 32'h65B6;
	wire bv, bw, bf, be, bd, rt;
	wire [31:0] ba, bdt;
	wire [1:0] bs;
	int err_total, check_count, cyc_n, i;
	logic [31:0] q[4] = '{32'h05, 32'h03, 32'h11, 32'h09};
	logic [4:0] mk[4] = '{5'h01, 5'h05, 5'h01, 5'h02};
	logic [4:0] hk[4] = '{5'h05, 5'h01, 5'h02, 5'h01};
	bbcm_matcher i_dut (.core_clk_i(ck), .rst_i(rs), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
		.pready_o(prdy), .pslverr_o(perr), .prdata_o(prd), .bus_valid_i(bv),
		.bus_addr_i(ba), .bus_data_i(bdt), .bus_write_i(bw), .bus_size_i(bs),
		.bus_fetch_i(bf), .bus_exec_i(be), .bus_dma_i(bd), .bus_pc_rel_i(pcr),
		.insn_retire_i(rt), .insn_in_slot_i(slot), .sw_break_exec_i(swb),
		.run_stop_addr_i(rsa), .stepping_i(step),
		.external_probe_trigger_i(probe), .stop_req_o(stop), .hit_units_o(hit));
	bbcm_core_model i_core (.clk_i(ck), .valid_o(bv), .addr_o(ba), .data_o(bdt),
		.wr_o(bw), .size_o(bs), .fetch_o(bf), .exec_o(be), .dma_o(bd),
		.retire_o(rt));
	initial begin
		ck = 1'b0;
		forever #10 ck = ~ck;
	end
	always @(posedge ck) begin
		cyc_n++;
		if (cyc_n == 5000) begin
			err_total++;
			close_out();
		end
	end
	function automatic logic [31:0] xs();
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction
	function automatic logic [4:0] unit(input int n);
		return 5'h01 << (n - 1);
	endfunction
	task chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task apb(input logic w, input logic [11:0] ad, input logic [31:0] dt);
		{psel, pen, pwr, pa, pwd} <= {2'h2, w, ad, dt};
		@(posedge ck);
		pen <= 1'b1;
		@(posedge ck);
		while (prdy !== 1'b1)
			@(posedge ck);
		r = prd;
		pe = perr;
		{psel, pen} <= 2'h0;
		@(posedge ck);
	endtask
	task wr(input logic [11:0] ad, input logic [31:0] dt);
		apb(1'b1, ad, dt);
	endtask
	task rd(input logic [11:0] ad, input logic [31:0] e);
		apb(1'b0, ad, 32'h0);
		chk(r, e);
	endtask
	// Two retirements, then the stop request and its clear
	task settle(input logic [4:0] e);
		int k;
		i_core.retire(2'(xs()));
		chk(32'(stop), 32'h0);
		i_core.retire(2'(xs()));
		for (k = 0; k < 8 && stop !== 1'b1; k++)
			@(posedge ck);
		chk(32'(stop), 32'(e != 5'h00));
		if (e != 5'h00) begin
			chk(32'(hit), 32'(e));
			wr(`BBCM_A_CTRL, 32'h1);
			chk(32'(stop), 32'h0);
		end
	endtask
	task close_out();
		if (err_total == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		{rs, psel, pen, pwr, probe, step, swb, pcr, slot, rsa, pa, pwd} =
			{10'h200, 44'h0};
		repeat (10) @(posedge ck);
		rs <= 1'b0;
		@(posedge ck);
		rd(`BBCM_A_STATUS, 32'h1);
		rd(`BBCM_A_U3_CFG, 32'h0);
		rd(12'h100, 32'h0);
		chk(32'(pe), 32'h1);
		for (i = 0; i < 4; i++) begin
			a = xs();
			wr(`BBCM_A_U3_ADDR, a);
			wr(`BBCM_A_U3_CFG, 32'h1);
			i_core.cyc(a ^ (32'h1 << (i * 8 + 7)), xs(), 5'(i % 3));
			settle(5'h00);
			i_core.cyc(a, xs(), 5'(i % 3));
			settle(unit(3));
			a = xs();
			wr(`BBCM_A_U4_ADDR, a);
			wr(`BBCM_A_U4_CFG, q[i]);
			i_core.cyc(a, xs(), mk[i]);
			settle(5'h00);
			i_core.cyc(a, xs(), hk[i]);
			settle(unit(4));
		end
		i_core.cyc(a, xs(), 5'h00);
		settle(5'h00);
		pcr <= 1'b1;
		i_core.cyc(a, xs(), 5'h00);
		pcr <= 1'b0;
		settle(unit(4));
		a = xs() & 32'hFFFFFFF0;
		d = xs();
		wr(`BBCM_A_U1_ADDR, a);
		wr(`BBCM_A_U1_AMSK, 32'hF);
		wr(`BBCM_A_U1_DATA, d);
		wr(`BBCM_A_U1_DMSK, 32'hF0);
		wr(`BBCM_A_U1_CFG, 32'h41);
		i_core.cyc(a, d ^ 32'h100, 5'h11);
		settle(5'h00);
		i_core.cyc(a, d, 5'h09);
		settle(5'h00);
		i_core.cyc(a | 32'h8, d ^ 32'h30, 5'h11);
		settle(unit(1));
		wr(`BBCM_A_U1_CFG, 32'h30041);
		i_core.cyc(a, d, 5'h11);
		i_core.cyc(xs(), d, 5'h01);
		i_core.cyc(xs(), d, 5'h01);
		settle(5'h00);
		i_core.cyc(xs(), d, 5'h01);
		settle(unit(1));
		rd(`BBCM_A_DLY_CNT, 32'h3);
		wr(`BBCM_A_U5_CFG, 32'h1);
		probe <= 1'b1;
		@(posedge ck);
		probe <= 1'b0;
		settle(unit(5));
		a = xs();
		wr(`BBCM_A_U2_ADDR, a);
		wr(`BBCM_A_U2_CFG, 32'h81);
		step <= 1'b1;
		i_core.cyc(a, d, 5'h00);
		settle(5'h00);
		step <= 1'b0;
		rsa <= 1'b1;
		i_core.cyc(a, d, 5'h00);
		settle(5'h00);
		rsa <= 1'b0;
		slot <= 1'b1;
		i_core.cyc(a, d, 5'h00);
		i_core.retire(2'h0);
		i_core.retire(2'h0);
		repeat (3) @(posedge ck);
		chk(32'(stop), 32'h0);
		slot <= 1'b0;
		repeat (3) @(posedge ck);
		chk(32'(stop), 32'h1);
		chk(32'(hit), 32'(unit(2)));
		wr(`BBCM_A_CTRL, 32'h1);
		chk(32'(stop), 32'h0);
		swb <= 1'b1;
		i_core.cyc(~a, d, 5'h00);
		swb <= 1'b0;
		rd(`BBCM_A_U2_CFG, 32'h0);
		wr(`BBCM_A_CANCEL, 32'h4);
		rd(`BBCM_A_U3_CFG, 32'h0);
		rd(`BBCM_A_U4_CFG, 32'h9);
		wr(`BBCM_A_CANCEL, 32'h0);
		rd(`BBCM_A_U4_CFG, 32'h0);
		rd(`BBCM_A_U5_CFG, 32'h0);
		a = xs() | 32'h1;
		wr(`BBCM_A_SEQ_P0, a);
		rd(`BBCM_A_SEQ_P0, a & 32'hFFFFFFFE);
		d = xs() & 32'hFFFFFFFE;
		wr(`BBCM_A_SEQ_P1, d);
		wr(`BBCM_A_SEQ_RST, ~d);
		wr(`BBCM_A_SEQ_CFG, 32'hA);
		i_core.cyc(a, d, 5'h00);
		rd(`BBCM_A_STATUS, 32'h101);
		i_core.cyc(~d, d, 5'h00);
		rd(`BBCM_A_STATUS, 32'h1);
		i_core.cyc(a, d, 5'h00);
		i_core.cyc(a, d, 5'h00);
		rd(`BBCM_A_STATUS, 32'h101);
		close_out();
	end
endmodule // bus_break_condition_matcher_tb
`default_nettype wire
